// [v86_pkg.sv]
// Purpose: Shared constants and types for the virtual-8086 interrupt unit
// Assumes: Classic Wishbone slave, 32-bit data, byte address
// Notes: Flag bit positions follow the processor flags word layout
package v86_pkg;

  // Flag bit positions in flags_register
  localparam int FLAG_IF = 9;
  localparam int FLAG_IO_PRIVILEGE_LEVEL_LO = 12;
  localparam int FLAG_IO_PRIVILEGE_LEVEL_HI = 13;
  localparam int FLAG_NT = 14;
  localparam int FLAG_VM = 17;
  localparam int FLAG_VIF = 19;
  localparam int FLAG_VIP = 20;
  localparam logic [1:0] IO_PRIVILEGE_LEVEL_TOP = 2'h3;
  localparam logic [1:0] CPL_ZERO = 2'h0;
  localparam logic [31:0] FLAGS_RESET = 32'h0000_0002;
  localparam logic [15:0] SEG_ZERO = 16'h0000;

  // Register byte offsets
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_CMD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_CUR_SEL = 8'h10;
  localparam logic [7:0] OFS_NEW_SEL = 8'h14;
  localparam logic [7:0] OFS_NEW_IMG = 8'h18;
  localparam logic [7:0] OFS_SAVED_IMG = 8'h1c;
  localparam logic [7:0] OFS_LINK = 8'h20;
  localparam logic [7:0] OFS_STK_IMG = 8'h24;
  localparam logic [7:0] OFS_SEG_DE = 8'h28;
  localparam logic [7:0] OFS_SEG_FG = 8'h2c;
  localparam logic [7:0] OFS_STK_DE = 8'h30;
  localparam logic [7:0] OFS_STK_FG = 8'h34;
  localparam logic [7:0] OFS_OPERAND = 8'h38;
  localparam logic [7:0] OFS_RESULT = 8'h3c;

  // Control register fields
  localparam int CTRL_VME = 0;
  localparam int CTRL_CPL_LO = 1;
  localparam int CTRL_CPL_HI = 2;
  localparam int CTRL_REAL = 3;

  // Status register fields
  localparam int STAT_FAULT = 0;
  localparam int STAT_VIRT = 1;
  localparam int STAT_V86 = 2;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_TASK_ENTRY = 4'h1,
    OP_INTERRUPT_RETURN_INSTR = 4'h2,
    OP_CLI = 4'h3,
    OP_STI = 4'h4,
    OP_PUSH_FLAGS_INSTR = 4'h5,
    OP_POP_FLAGS_INSTR = 4'h6,
    OP_INSN_START = 4'h7
  } op_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_type;

  typedef struct packed {
    logic [31:0] flags;
    logic virtual_mode_extensions_enable;
    logic [1:0] current_privilege_level;
    logic real_mode;
    logic [15:0] cur_sel;
    logic [15:0] new_sel;
    logic [31:0] new_img;
    logic [31:0] saved_img;
    logic [15:0] link;
    logic [31:0] tss_de;
    logic [31:0] tss_fg;
    logic [31:0] stk_img;
    logic [31:0] seg_de;
    logic [31:0] seg_fg;
    logic [31:0] stk_de;
    logic [31:0] stk_fg;
    logic [31:0] operand;
    logic [31:0] result;
    logic fault_seen;
    logic gp;
    logic int_ack;
    logic [7:0] vec;
    logic ack;
    logic [31:0] rdat;
  } state_type;

endpackage : v86_pkg

// [v86_interrupt_virtualization.sv]
// Purpose: Interrupt entry, return and virtual interrupt flags in v86 mode
// Assumes: Inputs synchronous to SYS_CLK; one command per bus write
// Notes: Commands stand for instructions retired by the core pipeline
// Operation
// - Task-gate entry saves flags with VM set
// - Handler task link gets interrupted task selector
// - Flags load from new task image, leaving v86
// - Task-gate entry sets nested task flag
// - Nested return restores v86 task flags, segments
// - Return changes VM only at privilege zero
// - Maskable requests refused while IF clear
// - VIRTUAL_INTERRUPT_ENABLE and VIRTUAL_INTERRUPT_PENDING active under VIRTUAL_MODE_EXTENSIONS_ENABLE, IO_PRIVILEGE_LEVEL below 3
// - CLEAR_INTERRUPT_INSTR and SET_INTERRUPT_INSTR act on VIRTUAL_INTERRUPT_ENABLE only
// - PUSH_FLAGS_INSTR and POP_FLAGS_INSTR use VIRTUAL_INTERRUPT_ENABLE instead of IF
// - IF alone decides interrupt acceptance
// - Hardware never writes the pending flag
// - Interrupt enters privilege zero, pushes state
// - Pushed image has IO_PRIVILEGE_LEVEL 3, IF from VIRTUAL_INTERRUPT_ENABLE
// - Entry clears segments and VM, then fetches
// - SET_INTERRUPT_INSTR faults when pending set, else enables
// - VIRTUAL_INTERRUPT_ENABLE and VIRTUAL_INTERRUPT_PENDING both set fault at instruction
// - Virtual flags untouched in real-address mode
// - Without VIRTUAL_MODE_EXTENSIONS_ENABLE, legacy handling without virtual flags
// - Data segments loaded with zero after push
`timescale 1ns/1ps
module v86_interrupt_virtualization (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Wishbone slave
  input wire v86_pkg::wb_req_type WB_REQ,
  output v86_pkg::wb_rsp_type WB_RSP,
  // Maskable interrupt sources
  input wire logic MASKABLE_INTERRUPT_PIN,
  input wire logic LOCAL_CTRL_REQ,
  input wire logic [7:0] INT_VECTOR,
  // Core side events
  output logic INT_ACK,
  output logic [7:0] INT_ACK_VECTOR,
  output logic GP_FAULT,
  output logic V86_MODE
);
  import v86_pkg::*;

  state_type q;
  state_type d;

  // Byte-lane merge of a bus write into a word
  function automatic logic [31:0] lane_write(input logic [31:0] old,
                                             input wb_req_type r);
    logic [31:0] v;
    v = old;
    for (int i = 0; i < 4; i++) begin
      if (r.sel[i]) begin
        v[i*8 +: 8] = r.dat[i*8 +: 8];
      end
    end
    return v;
  endfunction : lane_write

  // Hardware flag update: pending flag always kept from the old word
  function automatic logic [31:0] hw_flags(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic real_md);
    logic [31:0] v;
    v = nw;
    v[FLAG_VIP] = old[FLAG_VIP];
    if (real_md) begin
      v[FLAG_VIF] = old[FLAG_VIF];
    end
    return v;
  endfunction : hw_flags

  logic req_live;
  logic wr;
  logic virt;
  logic priv_ok;
  logic irq;
  logic [31:0] cur_w;
  logic [31:0] new_w;
  op_type op;

  always_comb begin
    d = q;
    d.gp = 1'b0;
    d.int_ack = 1'b0;
    d.ack = 1'b0;
    op = OP_NONE;
    req_live = WB_REQ.cyc & WB_REQ.stb & ~q.ack;
    wr = req_live & WB_REQ.we;
    // Virtual flags live only in v86 mode with VIRTUAL_MODE_EXTENSIONS_ENABLE and IO_PRIVILEGE_LEVEL below 3
    virt = q.virtual_mode_extensions_enable & q.flags[FLAG_VM] & ~q.real_mode &
           (q.flags[FLAG_IO_PRIVILEGE_LEVEL_HI:FLAG_IO_PRIVILEGE_LEVEL_LO] < IO_PRIVILEGE_LEVEL_TOP);
    priv_ok = q.current_privilege_level <= q.flags[FLAG_IO_PRIVILEGE_LEVEL_HI:FLAG_IO_PRIVILEGE_LEVEL_LO];
    irq = MASKABLE_INTERRUPT_PIN | LOCAL_CTRL_REQ;
    // Selector merges go through a word, as a call result cannot be sliced
    cur_w = lane_write({16'h0, q.cur_sel}, WB_REQ);
    new_w = lane_write({16'h0, q.new_sel}, WB_REQ);

    // Read path: unmapped offsets read as zero
    if (req_live) begin
      d.ack = 1'b1;
      case (WB_REQ.adr)
        OFS_FLAGS: d.rdat = q.flags;
        OFS_CTRL: d.rdat = {28'h0, q.real_mode, q.current_privilege_level, q.virtual_mode_extensions_enable};
        OFS_STATUS: d.rdat = {29'h0, q.flags[FLAG_VM], virt,
                              q.fault_seen};
        OFS_CUR_SEL: d.rdat = {16'h0, q.cur_sel};
        OFS_NEW_SEL: d.rdat = {16'h0, q.new_sel};
        OFS_NEW_IMG: d.rdat = q.new_img;
        OFS_SAVED_IMG: d.rdat = q.saved_img;
        OFS_LINK: d.rdat = {16'h0, q.link};
        OFS_STK_IMG: d.rdat = q.stk_img;
        OFS_SEG_DE: d.rdat = q.seg_de;
        OFS_SEG_FG: d.rdat = q.seg_fg;
        OFS_STK_DE: d.rdat = q.stk_de;
        OFS_STK_FG: d.rdat = q.stk_fg;
        OFS_OPERAND: d.rdat = q.operand;
        OFS_RESULT: d.rdat = q.result;
        default: d.rdat = 32'h0;
      endcase
    end

    // Write path: software alone may change the pending flag
    if (wr) begin
      case (WB_REQ.adr)
        OFS_FLAGS: d.flags = lane_write(q.flags, WB_REQ);
        OFS_CTRL: begin
          if (WB_REQ.sel[0]) begin
            d.virtual_mode_extensions_enable = WB_REQ.dat[CTRL_VME];
            d.current_privilege_level = WB_REQ.dat[CTRL_CPL_HI:CTRL_CPL_LO];
            d.real_mode = WB_REQ.dat[CTRL_REAL];
          end
        end
        OFS_CMD: begin
          if (WB_REQ.sel[0]) begin
            op = op_type'(WB_REQ.dat[3:0]);
          end
        end
        OFS_STATUS: begin
          if (WB_REQ.sel[0] & WB_REQ.dat[STAT_FAULT]) begin
            d.fault_seen = 1'b0;
          end
        end
        OFS_CUR_SEL: d.cur_sel = cur_w[15:0];
        OFS_NEW_SEL: d.new_sel = new_w[15:0];
        OFS_NEW_IMG: d.new_img = lane_write(q.new_img, WB_REQ);
        OFS_SAVED_IMG: d.saved_img = lane_write(q.saved_img, WB_REQ);
        OFS_STK_IMG: d.stk_img = lane_write(q.stk_img, WB_REQ);
        OFS_SEG_DE: d.seg_de = lane_write(q.seg_de, WB_REQ);
        OFS_SEG_FG: d.seg_fg = lane_write(q.seg_fg, WB_REQ);
        OFS_OPERAND: d.operand = lane_write(q.operand, WB_REQ);
        default: d.rdat = d.rdat;
      endcase
    end

    case (op)
      OP_TASK_ENTRY: begin
        d.saved_img = q.flags;
        d.tss_de = q.seg_de;
        d.tss_fg = q.seg_fg;
        d.link = q.cur_sel;
        d.cur_sel = q.new_sel;
        d.flags = hw_flags(q.flags, q.new_img, q.real_mode);
        d.flags[FLAG_NT] = 1'b1;
      end
      OP_INTERRUPT_RETURN_INSTR: begin
        if (q.flags[FLAG_NT]) begin
          // Task switch back to the interrupted v86 task
          d.flags = hw_flags(q.flags, q.saved_img, q.real_mode);
          d.seg_de = q.tss_de;
          d.seg_fg = q.tss_fg;
          d.cur_sel = q.link;
        end else begin
          // Stack return from a gate-entered handler
          d.flags = hw_flags(q.flags, q.stk_img, q.real_mode);
          d.seg_de = q.stk_de;
          d.seg_fg = q.stk_fg;
        end
        if (q.current_privilege_level != CPL_ZERO) begin
          d.flags[FLAG_VM] = q.flags[FLAG_VM];
        end
      end
      OP_CLI: begin
        if (virt) begin
          d.flags[FLAG_VIF] = 1'b0;
        end else if (priv_ok) begin
          d.flags[FLAG_IF] = 1'b0;
        end else begin
          d.gp = 1'b1;
        end
      end
      OP_STI: begin
        if (virt) begin
          if (q.flags[FLAG_VIP]) begin
            d.gp = 1'b1;
          end else begin
            d.flags[FLAG_VIF] = 1'b1;
          end
        end else if (priv_ok) begin
          d.flags[FLAG_IF] = 1'b1;
        end else begin
          d.gp = 1'b1;
        end
      end
      OP_PUSH_FLAGS_INSTR: begin
        d.result = q.flags;
        if (virt) begin
          d.result[FLAG_IF] = q.flags[FLAG_VIF];
        end
      end
      OP_POP_FLAGS_INSTR: begin
        // Mode, privilege and pending bits are never taken from the stack; VIF takes the popped IF only when virt is set
        d.flags = q.operand;
        d.flags[FLAG_VM] = q.flags[FLAG_VM];
        d.flags[FLAG_VIF] = q.flags[FLAG_VIF];
        d.flags[FLAG_VIP] = q.flags[FLAG_VIP];
        d.flags[FLAG_IO_PRIVILEGE_LEVEL_HI:FLAG_IO_PRIVILEGE_LEVEL_LO] =
          q.flags[FLAG_IO_PRIVILEGE_LEVEL_HI:FLAG_IO_PRIVILEGE_LEVEL_LO];
        if (virt) begin
          d.flags[FLAG_IF] = q.flags[FLAG_IF];
          d.flags[FLAG_VIF] = q.operand[FLAG_IF];
        end else if (!priv_ok) begin
          d.flags[FLAG_IF] = q.flags[FLAG_IF];
        end
      end
      OP_INSN_START: begin
        if (virt & q.flags[FLAG_VIF] & q.flags[FLAG_VIP]) begin
          d.gp = 1'b1;
        end
      end
      default: d.gp = 1'b0;
    endcase

    // A request waits while a command runs, so one event per cycle
    if (op == OP_NONE && irq && q.flags[FLAG_IF]) begin
      d.int_ack = 1'b1;
      d.vec = INT_VECTOR;
      d.current_privilege_level = CPL_ZERO;
      d.stk_img = q.flags;
      d.stk_de = q.seg_de;
      d.stk_fg = q.seg_fg;
      if (virt) begin
        d.stk_img[FLAG_IO_PRIVILEGE_LEVEL_HI:FLAG_IO_PRIVILEGE_LEVEL_LO] = IO_PRIVILEGE_LEVEL_TOP;
        d.stk_img[FLAG_IF] = q.flags[FLAG_VIF];
      end
      // Legacy path shares the same push, without the virtual edits
      d.seg_de = {SEG_ZERO, SEG_ZERO};
      d.seg_fg = {SEG_ZERO, SEG_ZERO};
      d.flags[FLAG_VM] = 1'b0;
      d.flags[FLAG_NT] = 1'b0;
    end

    // Set wins over a same-cycle clear
    if (d.gp) begin
      d.fault_seen = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.flags <= FLAGS_RESET;
    end else begin
      q <= d;
    end
  end

  assign WB_RSP.ack = q.ack;
  assign WB_RSP.dat = q.rdat;
  assign INT_ACK = q.int_ack;
  assign INT_ACK_VECTOR = q.vec;
  assign GP_FAULT = q.gp;
  assign V86_MODE = q.flags[FLAG_VM];

endmodule : v86_interrupt_virtualization

// [v86_irq_properties.sv]
// Purpose: Port properties of the v86 interrupt unit
// Assumes: One clock, reset active low
// Notes: Flags are internal, so events are tied to their causes
`timescale 1ns/1ps
module v86_irq_properties (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESETN,
  // Bus
  input wire v86_pkg::wb_req_type WB_REQ,
  input wire v86_pkg::wb_rsp_type WB_RSP,
  // Interrupt side
  input wire logic MASKABLE_INTERRUPT_PIN,
  input wire logic LOCAL_CTRL_REQ,
  input wire logic [7:0] INT_VECTOR,
  input wire logic INT_ACK,
  input wire logic [7:0] INT_ACK_VECTOR,
  // Core events
  input wire logic GP_FAULT,
  input wire logic V86_MODE
);
  import v86_pkg::*;
  logic wr_raw;
  logic cmd_raw;
  assign wr_raw = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & ~WB_RSP.ack;
  assign cmd_raw = wr_raw & (WB_REQ.adr == OFS_CMD);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  sequence taken_s;
    WB_REQ.cyc && WB_REQ.stb && !WB_RSP.ack;
  endsequence
  sequence answer_s;
    WB_RSP.ack ##1 !WB_RSP.ack;
  endsequence
  bus_answer_a: assert property (taken_s |=> answer_s)
    else $error("bus ack not a one cycle answer");
  gp_cause_a: assert property (GP_FAULT |-> $past(cmd_raw))
    else $error("fault without command");
  gp_pulse_a: assert property (GP_FAULT |=> !GP_FAULT)
    else $error("fault too long");
  int_cause_a: assert property (INT_ACK |->
    $past(MASKABLE_INTERRUPT_PIN | LOCAL_CTRL_REQ) && !$past(cmd_raw))
    else $error("accept without request");
  vec_take_a: assert property
    (INT_ACK |-> INT_ACK_VECTOR == $past(INT_VECTOR))
    else $error("wrong vector");
  vec_hold_a: assert property (!INT_ACK |-> $stable(INT_ACK_VECTOR))
    else $error("vector moved");
  int_exit_a: assert property (INT_ACK |-> !V86_MODE)
    else $error("still in v86 after entry");
  mode_cause_a: assert property
    ($changed(V86_MODE) |-> $past(wr_raw) || INT_ACK)
    else $error("mode changed without cause");
endmodule : v86_irq_properties
bind v86_interrupt_virtualization v86_irq_properties v86_irq_properties_i (
  .SYS_CLK, .RESETN, .WB_REQ, .WB_RSP, .MASKABLE_INTERRUPT_PIN,
  .LOCAL_CTRL_REQ, .INT_VECTOR, .INT_ACK, .INT_ACK_VECTOR, .GP_FAULT,
  .V86_MODE);

// [v86_monitor_model.sv]
// Purpose: Requester and monitor stand-in for the interrupt unit
// Assumes: Request drops in the cycle the unit answers
// Notes: Vector is inverted while idle so stale values never match
`timescale 1ns/1ps
module v86_monitor_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bench control
  input wire logic go,
  input wire logic src,
  input wire logic serviced,
  input wire logic [7:0] vec_in,
  input wire logic [31:0] img_in,
  // Unit side
  input wire logic int_ack,
  output logic pin,
  output logic local_req,
  output logic [7:0] vec,
  output logic [31:0] img_out
);
  import v86_pkg::*;
  logic req_q;
  logic src_q;
  logic [7:0] vec_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= 1'b0;
      src_q <= 1'b0;
      vec_q <= 8'h00;
    end else if (go) begin
      req_q <= 1'b1;
      src_q <= src;
      vec_q <= vec_in;
    end else if (int_ack) begin
      req_q <= 1'b0;
    end
  end
  // Dropping on the answer avoids a second accept of the same request
  assign pin = req_q & ~src_q & ~int_ack;
  assign local_req = req_q & src_q & ~int_ack;
  assign vec = (pin | local_req) ? vec_q : ~vec_q;
  always_comb begin
    img_out = img_in;
    if (serviced) begin
      img_out[FLAG_VIP] = 1'b0;
      img_out[FLAG_VIF] = 1'b1;
    end else if (!img_in[FLAG_VIF]) begin
      img_out[FLAG_VIP] = 1'b1;
    end
  end
endmodule : v86_monitor_model

// [tb_v86_interrupt_virtualization.sv]
// Purpose: Self-checking bench for the v86 interrupt unit
// Assumes: Bus answers one cycle after a request
// Notes: Reads and vectors are queued; a watcher compares
`timescale 1ns/1ps
module tb_v86_interrupt_virtualization;
  import v86_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic go = 1'b0;
  logic src = 1'b0;
  logic svc = 1'b0;
  logic pin, lreq, iack, gp, v86;
  logic [7:0] vgo = 8'h00;
  logic [7:0] vec, avec;
  logic [31:0] img_in = 32'h0;
  logic [31:0] img, s1, s2;
  logic [31:0] rnd = 32'haf85;
  wb_req_type req = '0;
  wb_rsp_type rsp;
  logic [31:0] eq[$];
  logic [7:0] vq[$];
  int error_cnt = 0;
  int n_compared = 0;
  int gps = 0;
  int cyc_n = 0;
  always #5 clk = ~clk;
  v86_interrupt_virtualization v86_interrupt_virtualization_i (.SYS_CLK(clk),
    .RESETN(resetn), .WB_REQ(req), .WB_RSP(rsp), .MASKABLE_INTERRUPT_PIN(pin),
    .LOCAL_CTRL_REQ(lreq), .INT_VECTOR(vec), .INT_ACK(iack),
    .INT_ACK_VECTOR(avec), .GP_FAULT(gp), .V86_MODE(v86));
  v86_monitor_model v86_monitor_model_i (.clk(clk), .rst_n(resetn), .go(go),
    .src(src), .serviced(svc), .vec_in(vgo), .img_in(img_in), .int_ack(iack),
    .pin(pin), .local_req(lreq), .vec(vec), .img_out(img));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, logic w = 1);
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do @(posedge clk); while (rsp.ack !== 1'b1);
    req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    eq.push_back(e);
    wr(a, 32'h0, 1'b0);
  endtask : rd
  task automatic cmd(input op_type c);
    wr(OFS_CMD, {28'h0, c});
  endtask : cmd
  task automatic raise(input logic s);
    rnd = xs(rnd);
    @(posedge clk);
    go <= 1'b1;
    src <= s;
    vgo <= rnd[7:0];
    @(posedge clk);
    go <= 1'b0;
    vq.push_back(rnd[7:0]);
  endtask : raise
  task automatic give_verdict();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (rsp.ack === 1'b1 && req.we === 1'b0)
      chk("read", eq.size() > 0 ? eq.pop_front() : 'x, rsp.dat);
    if (iack === 1'b1)
      chk("vector", vq.size() > 0 ? vq.pop_front() : 'x, {24'h0, avec});
    if (gp === 1'b1)
      gps++;
    if (cyc_n == 5000) begin
      error_cnt++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    wr(OFS_CTRL, 32'h7);
    wr(OFS_FLAGS, 32'h0002_0202);
    cmd(OP_STI);
    rd(OFS_FLAGS, 32'h000a_0202);
    cmd(OP_CLI);
    rd(OFS_FLAGS, 32'h0002_0202);
    cmd(OP_STI);
    wr(OFS_OPERAND, 32'h2);
    cmd(OP_POP_FLAGS_INSTR);
    rd(OFS_FLAGS, 32'h0002_0202);
    cmd(OP_PUSH_FLAGS_INSTR);
    rd(OFS_RESULT, 32'h0002_0002);
    img_in <= 32'h0002_0202;
    @(posedge clk);
    wr(OFS_FLAGS, img);
    cmd(OP_STI);
    rd(OFS_FLAGS, 32'h0012_0202);
    rd(OFS_STATUS, 32'h7);
    img_in <= 32'h0012_0202;
    svc <= 1'b1;
    @(posedge clk);
    chk("serviced image", 32'h000a_0202, img);
    svc <= 1'b0;
    rnd = xs(rnd);
    s1 = rnd;
    rnd = xs(rnd);
    s2 = rnd;
    wr(OFS_SEG_DE, s1);
    wr(OFS_SEG_FG, s2);
    raise(1'b0);
    repeat (4) @(posedge clk);
    rd(OFS_STK_IMG, 32'h0012_3002);
    rd(OFS_STK_DE, s1);
    rd(OFS_STK_FG, s2);
    rd(OFS_SEG_FG, 32'h0);
    chk("mode", 32'h0, {31'h0, v86});
    wr(OFS_FLAGS, 32'h0);
    raise(1'b1);
    repeat (20) @(posedge clk);
    vq.push_back(vgo);
    void'(vq.pop_front());
    wr(OFS_FLAGS, 32'h0000_0202);
    repeat (4) @(posedge clk);
    for (int k = 0; k < 2; k++) begin
      rnd = xs(rnd);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_FLAGS, 32'h0002_0002);
      wr(OFS_CUR_SEL, {16'h0, rnd[15:0]});
      wr(OFS_NEW_SEL, {16'h0, rnd[31:16]});
      wr(OFS_NEW_IMG, 32'h2);
      cmd(OP_TASK_ENTRY);
      rd(OFS_SAVED_IMG, 32'h0002_0002);
      rd(OFS_LINK, {16'h0, rnd[15:0]});
      rd(OFS_FLAGS, 32'h0000_4002);
      wr(OFS_CTRL, k ? 32'h6 : 32'h0);
      cmd(OP_INTERRUPT_RETURN_INSTR);
      rd(OFS_FLAGS, k ? 32'h2 : 32'h0002_0002);
      rd(OFS_CUR_SEL, {16'h0, rnd[15:0]});
    end
    wr(OFS_CTRL, 32'h7);
    wr(OFS_FLAGS, 32'h001a_0202);
    cmd(OP_INSN_START);
    wr(OFS_CTRL, 32'hf);
    wr(OFS_FLAGS, 32'h0018_0202);
    cmd(OP_POP_FLAGS_INSTR);
    rd(OFS_FLAGS, 32'h0018_0202);
    cmd(OP_CLI);
    rd(OFS_FLAGS, 32'h0018_0202);
    rd(8'hf0, 32'h0);
    repeat (3) @(posedge clk);
    chk("faults", 32'd3, 32'(gps));
    give_verdict();
  end
endmodule : tb_v86_interrupt_virtualization
